// [rtl/dwm_pkg.sv]
// Package of shared constants and types for the write-leveling and calibration-pattern block
`default_nettype none
package dwm_pkg;
  // Command pins as sampled on a rising CK edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] a;
  } dwm_cmd_s;

  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;

  // Mode register selects on the bank address
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR3 = 3'h3;

  // Mode register field positions
  localparam int MR1_WL_BIT = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR1_RTT0_BIT = 2;
  localparam int MR1_RTT1_BIT = 6;
  localparam int MR1_RTT2_BIT = 9;
  localparam int MR1_AL_LSB = 3;
  localparam int MR3_MPR_BIT = 2;
  localparam int MR0_CL_LSB = 4;
  localparam int ADDR_BC_BIT = 12;
  localparam int ADDR_NIB_BIT = 2;

  // Burst length field of MR0 and base CAS latency
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [4:0] CL_BASE = 5'h04;

  // Pattern store: position 0 is the LSB
  localparam logic [7:0] PATTERN_LOC0 = 8'hAA;
  localparam logic [7:0] PATTERN_RFU = 8'h00;
  localparam logic [1:0] LOC_PREDEF = 2'h0;

  // Timing, in CK cycles, core clock cycles or picoseconds
  localparam logic [3:0] TMOD_NCK = 4'hC;
  localparam int CLK_PS = 8000;
  localparam int TWLO_PS = 7500;
  localparam int TWLO_CYC = (TWLO_PS / CLK_PS) < 1 ? 1 : (TWLO_PS / CLK_PS);

  // Register byte offsets and reset values
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_MR0 = 5'h08;
  localparam logic [4:0] OFS_MR1 = 5'h0C;
  localparam logic [4:0] OFS_MR3 = 5'h10;
  localparam int CTRL_FB_ALL_BIT = 0;
  localparam int CTRL_MIRROR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [13:0] MR_RESET = 14'h0000;
endpackage
`default_nettype wire

// [rtl/dwm_sync.sv]
// Two-flop synchroniser with edge detection on the synchronised level
`default_nettype none
module dwm_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta_r; // First stage, read only by the second
  logic [W-1:0] sync_r; // Second stage, safe to use
  logic [W-1:0] last_r; // Previous safe level for edges

  // Refuse a zero width
  if (W < 1) begin : g_chk
    $error("dwm_sync: width must be at least one");
  end

  // Synchroniser chain
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Level and edges come only from the second stage onward
  assign q_o = sync_r;
  assign rise_o = sync_r & ~last_r;
  assign fall_o = ~sync_r & last_r;
endmodule
`default_nettype wire

// [rtl/dwm_top.sv]
// Write-leveling feedback and calibration-pattern read logic of the memory device
`default_nettype none
// Operation
// - MR1 A7 enters and leaves write leveling
// - Leveling: ODT switches strobe termination only
// - Exit MRS may update other MR1 bits
// - ODT accepted only after tMOD from entry
// - Strobe rise samples CK, driven after tWLO
// - Prime bit feedback, other bits low/copy
// - Exit: stop strobes, ODT low, then MRS
// - MR3 A2 set enables pattern mode
// - Pattern mode redirects reads, A[1:0] selects
// - Auto precharge read acts as plain read
// - Pattern mode and leveling off: array serves accesses
// - Pattern bit on bit 0, others copy/zero
// - A2 picks nibble order for chop
// - Burst chop and normal latency honoured
// - Burst position 0 is pattern LSB
// - Location 00 returns alternating 0,1 pattern
module dwm_top (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ck_i,
  input wire dwm_pkg::dwm_cmd_s cmd_i,
  input wire logic odt_i,
  input wire logic [1:0] dqs_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_o,
  output logic rtt_dqs_on_o,
  output logic rtt_dq_on_o,
  output logic array_rd_o,
  output logic array_wr_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT = 2'b01,
    ST_BURST = 2'b10
  } dwm_rd_e;

  logic ck_lvl, ck_rise, ck_fall; // Sampled CK and its edges
  logic odt_lvl; // Sampled ODT
  logic [1:0] dqs_rise; // Strobe rises per byte lane
  dwm_pkg::dwm_cmd_s cmd_q; // Sampled command bundle
  logic [13:0] mr0_r, mr1_r, mr3_r; // Mode register copies
  logic [1:0] ctrl_r; // Software feedback and mirror options
  logic [3:0] mod_cnt_r; // CK rises left before ODT is honoured
  logic [1:0] samp_r; // Last CK level seen per lane
  // Delay depth must be known before the delay line is declared
  localparam int TWLO_CYCS = dwm_pkg::TWLO_CYC;
  logic [1:0] fb_dly_r [TWLO_CYCS]; // Feedback delayed by tWLO
  dwm_rd_e st_r;
  logic [4:0] lat_cnt_r; // CK rises to first data beat
  logic [3:0] beat_r; // Beat index within burst
  logic [3:0] len_r; // Beats in current burst
  logic [2:0] start_r; // First burst position
  logic [7:0] pat_r; // Selected pattern for this burst
  logic [2:0] pos; // Current burst position
  logic pat_bit; // Current pattern bit
  logic [3:0] code; // Command code
  logic cmd_go; // A command is taken at this CK rise
  logic wl, qoff, mpr_en, odt_ok, rtt_nom_en;
  logic wl_entry; // MRS turning leveling on
  logic [4:0] cl, al, rl; // Read latency pieces
  logic [3:0] len_nxt;
  logic [2:0] start_nxt;
  logic ack_r; // Bus answer phase

  // Sample the pins from the CK domain
  dwm_sync #(.W(1)) u_ck (.core_clk_i(core_clk_i), .reset_i(reset_i), .d_i(ck_i),
    .q_o(ck_lvl), .rise_o(ck_rise), .fall_o(ck_fall));
  dwm_sync #(.W(1)) u_odt (.core_clk_i(core_clk_i), .reset_i(reset_i), .d_i(odt_i),
    .q_o(odt_lvl), .rise_o(), .fall_o());
  dwm_sync #(.W(2)) u_dqs (.core_clk_i(core_clk_i), .reset_i(reset_i), .d_i(dqs_i),
    .q_o(), .rise_o(dqs_rise), .fall_o());
  // Command pins settle half a CK before the edge, so per-bit skew is harmless
  dwm_sync #(.W($bits(dwm_pkg::dwm_cmd_s))) u_cmd (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .d_i(cmd_i), .q_o(cmd_q), .rise_o(), .fall_o());

  // Decode of mode bits and the incoming command
  always_comb begin
    code = {cmd_q.cs_n, cmd_q.ras_n, cmd_q.cas_n, cmd_q.we_n};
    cmd_go = ck_rise;
    wl = mr1_r[dwm_pkg::MR1_WL_BIT];
    qoff = mr1_r[dwm_pkg::MR1_QOFF_BIT];
    mpr_en = mr3_r[dwm_pkg::MR3_MPR_BIT];
    odt_ok = wl && (mod_cnt_r == 4'h0);
    rtt_nom_en = mr1_r[dwm_pkg::MR1_RTT0_BIT] | mr1_r[dwm_pkg::MR1_RTT1_BIT]
      | mr1_r[dwm_pkg::MR1_RTT2_BIT];
    wl_entry = cmd_go && (code == dwm_pkg::CMD_MRS) && (cmd_q.ba == dwm_pkg::BA_MR1)
      && cmd_q.a[dwm_pkg::MR1_WL_BIT] && !wl;
  end

  // Read latency is AL + CL, same as for array reads
  always_comb begin
    cl = dwm_pkg::CL_BASE + {2'h0, mr0_r[dwm_pkg::MR0_CL_LSB +: 3]};
    case (mr1_r[dwm_pkg::MR1_AL_LSB +: 2])
      2'h1: al = cl - 5'h01;
      2'h2: al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    rl = cl + al;
  end

  // Burst length and starting nibble for a new read
  always_comb begin
    case (mr0_r[1:0])
      dwm_pkg::BL_FIXED4: len_nxt = 4'h4;
      dwm_pkg::BL_OTF: len_nxt = cmd_q.a[dwm_pkg::ADDR_BC_BIT] ? 4'h8 : 4'h4;
      default: len_nxt = 4'h8;
    endcase
    // Only the nibble select matters; bank and other column bits are ignored
    start_nxt = (len_nxt == 4'h4 && cmd_q.a[dwm_pkg::ADDR_NIB_BIT]) ? 3'h4 : 3'h0;
  end

  // Mode registers: every MRS to MR0, MR1 or MR3 stores the whole field, so the exit write updates all bits
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mr0_r <= dwm_pkg::MR_RESET;
      mr1_r <= dwm_pkg::MR_RESET;
      mr3_r <= dwm_pkg::MR_RESET;
    end else if (cmd_go && code == dwm_pkg::CMD_MRS) begin
      case (cmd_q.ba)
        dwm_pkg::BA_MR0: mr0_r <= cmd_q.a;
        dwm_pkg::BA_MR1: mr1_r <= cmd_q.a;
        dwm_pkg::BA_MR3: mr3_r <= cmd_q.a;
        default: ;
      endcase
    end
  end

  // tMOD wait after entering leveling before ODT is honoured
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mod_cnt_r <= dwm_pkg::TMOD_NCK;
    end else if (wl_entry) begin
      mod_cnt_r <= dwm_pkg::TMOD_NCK;
    end else if (ck_rise && mod_cnt_r != 4'h0) begin
      mod_cnt_r <= mod_cnt_r - 4'h1;
    end
  end

  // Termination; ODT latency of normal operation is not modelled here
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rtt_dqs_on_o <= 1'b0;
      rtt_dq_on_o <= 1'b0;
    end else if (wl) begin
      rtt_dqs_on_o <= odt_ok && odt_lvl;
      rtt_dq_on_o <= 1'b0;
    end else begin
      rtt_dqs_on_o <= odt_lvl && rtt_nom_en;
      rtt_dq_on_o <= odt_lvl && rtt_nom_en;
    end
  end

  // Each strobe rise during leveling captures the CK level and holds it until the next rise
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      samp_r <= 2'h0;
    end else begin
      for (int l = 0; l < 2; l++) begin
        if (wl && dqs_rise[l]) begin
          samp_r[l] <= ck_lvl;
        end
      end
    end
  end

  // Delay line standing for the feedback output delay
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < TWLO_CYCS; i++) begin
        fb_dly_r[i] <= 2'h0;
      end
    end else begin
      fb_dly_r[0] <= samp_r;
      for (int i = 1; i < TWLO_CYCS; i++) begin
        fb_dly_r[i] <= fb_dly_r[i-1];
      end
    end
  end

  // Read engine: latency count, then one beat per CK edge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      lat_cnt_r <= 5'h00;
      beat_r <= 4'h0;
      len_r <= 4'h8;
      start_r <= 3'h0;
      pat_r <= dwm_pkg::PATTERN_RFU;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // Both read forms share one code, so auto precharge is simply ignored
          if (cmd_go && code == dwm_pkg::CMD_RD && mpr_en) begin
            st_r <= ST_LAT;
            lat_cnt_r <= rl;
            len_r <= len_nxt;
            start_r <= start_nxt;
            pat_r <= (mr3_r[1:0] == dwm_pkg::LOC_PREDEF) ? dwm_pkg::PATTERN_LOC0
              : dwm_pkg::PATTERN_RFU;
          end
        end
        ST_LAT: begin
          if (ck_rise) begin
            if (lat_cnt_r <= 5'h01) begin
              st_r <= ST_BURST;
              beat_r <= 4'h0;
            end
            lat_cnt_r <= lat_cnt_r - 5'h01;
          end
        end
        ST_BURST: begin
          if (ck_rise || ck_fall) begin
            if (beat_r == len_r - 4'h1) begin
              st_r <= ST_IDLE;
            end
            beat_r <= beat_r + 4'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Pattern bit for the current burst position
  always_comb begin
    pos = start_r + beat_r[2:0];
    pat_bit = pat_r[pos];
  end

  // Data pin drive for both byte lanes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dq_o <= 16'h0000;
      dq_oe_o <= 16'h0000;
    end else if (wl) begin
      // Feedback needs no read strobe; a disabled output buffer keeps the rank quiet
      dq_oe_o <= qoff ? 16'h0000 : 16'hFFFF;
      for (int l = 0; l < 2; l++) begin
        dq_o[l*8 +: 8] <= ctrl_r[dwm_pkg::CTRL_FB_ALL_BIT] ? {8{fb_dly_r[TWLO_CYCS-1][l]}}
          : {7'h00, fb_dly_r[TWLO_CYCS-1][l]};
      end
    end else if (st_r == ST_BURST) begin
      dq_oe_o <= 16'hFFFF;
      for (int l = 0; l < 2; l++) begin
        dq_o[l*8 +: 8] <= ctrl_r[dwm_pkg::CTRL_MIRROR_BIT] ? {8{pat_bit}}
          : {7'h00, pat_bit};
      end
    end else begin
      // Outside these modes pins are released; after exit they stay released
      dq_o <= 16'h0000;
      dq_oe_o <= 16'h0000;
    end
  end

  // Array access requests, suppressed while the pattern path is on
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      array_rd_o <= 1'b0;
      array_wr_o <= 1'b0;
    end else begin
      array_rd_o <= cmd_go && code == dwm_pkg::CMD_RD && !mpr_en && !wl;
      array_wr_o <= cmd_go && code == dwm_pkg::CMD_WR && !mpr_en && !wl;
    end
  end

  // Bus handshake: one wait cycle, then the answer on the next edge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
    end
  end

  // Control register write, taken only at the accepting edge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= dwm_pkg::CTRL_RESET;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == dwm_pkg::OFS_CTRL) begin
      ctrl_r <= avs_writedata_i[1:0];
    end
  end

  // Read data, ready in the same cycle waitrequest drops; unmapped reads give zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_r) begin
      case (avs_address_i)
        dwm_pkg::OFS_CTRL: avs_readdata_o <= {30'h0, ctrl_r};
        dwm_pkg::OFS_STATUS: avs_readdata_o <= {26'h0, st_r != ST_IDLE, samp_r, odt_ok,
          mpr_en, wl};
        dwm_pkg::OFS_MR0: avs_readdata_o <= {18'h0, mr0_r};
        dwm_pkg::OFS_MR1: avs_readdata_o <= {18'h0, mr1_r};
        dwm_pkg::OFS_MR3: avs_readdata_o <= {18'h0, mr3_r};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  AST_WL_ENTER: assert property (wl_entry |=> wl)
    else $error("leveling not entered");
  AST_WL_EXIT: assert property (cmd_go && code == dwm_pkg::CMD_MRS
    && cmd_q.ba == dwm_pkg::BA_MR1 && !cmd_q.a[dwm_pkg::MR1_WL_BIT] |=> !wl)
    else $error("leveling not left");
  AST_DQ_TERM_OFF: assert property (wl |=> !rtt_dq_on_o)
    else $error("data termination on while leveling");
  AST_ODT_WAIT: assert property (wl_entry |=> (!rtt_dqs_on_o)[*8])
    else $error("ODT honoured before tMOD");
  AST_FB_VALUE: assert property (wl && dqs_rise[0] && !qoff |-> ##3
    (!wl || dq_o[0] == $past(ck_lvl, 3)))
    else $error("feedback not the sampled CK level");
  AST_PRIME_LOW: assert property (wl && !ctrl_r[dwm_pkg::CTRL_FB_ALL_BIT] |=>
    (dq_o[7:1] == 7'h00 && dq_o[15:9] == 7'h00))
    else $error("non-prime bits not low");
  AST_FB_HOLD: assert property (wl && $stable(wl) && dqs_rise == 2'h0 |=> $stable(samp_r))
    else $error("feedback changed without a strobe");
  AST_MPR_NO_ARRAY: assert property (mpr_en && cmd_go && code == dwm_pkg::CMD_RD
    |=> !array_rd_o)
    else $error("pattern-mode read went to the array");
  AST_NORMAL_ARRAY: assert property (!mpr_en && !wl && cmd_go && code == dwm_pkg::CMD_RD
    |=> array_rd_o)
    else $error("array read not issued");
  AST_PATTERN: assert property (st_r == ST_BURST && !wl && pat_r == dwm_pkg::PATTERN_LOC0
    |=> dq_o[0] == $past(pos[0]) && dq_o[8] == $past(pos[0]))
    else $error("wrong calibration bit");
  AST_BURST_LEN: assert property (st_r == ST_BURST |-> beat_r < len_r)
    else $error("burst ran past its length");
  AST_BC4_NIBBLE: assert property (st_r == ST_BURST && len_r == 4'h4 |-> start_r[1:0] == 2'h0)
    else $error("chop burst off nibble");

  COV_WL_FB: cover property (wl && dqs_rise[0] ##3 dq_o[0]);
  COV_MPR_BL8: cover property (st_r == ST_BURST && len_r == 4'h8 && beat_r == 4'h7);
  COV_MPR_BC4_HI: cover property (st_r == ST_BURST && len_r == 4'h4 && start_r == 3'h4);
  COV_BUS_RD: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
`default_nettype wire

// [sim/dwm_ctl_model.sv]
// Memory controller model: free-running CK, command pins, ODT and data strobes
`default_nettype none
module dwm_ctl_model (
  output logic ck_o,
  output dwm_pkg::dwm_cmd_s cmd_o,
  output logic odt_o,
  output logic [1:0] dqs_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // CK runs free; a 3 ns offset keeps it out of step with the core clock
  initial begin
    ck_o = 1'b0;
    cmd_o = {4'h7, 3'h0, 14'h0000};
    odt_o = 1'b0;
    dqs_o = 2'b00;
    #3;
    forever #40 ck_o = ~ck_o;
  end

  // One command for one CK rise, NOP on either side of it
  task automatic issue(input logic [3:0] op, input logic [2:0] ba, input logic [13:0] a);
    @(negedge ck_o);
    cmd_o <= {op, ba, a};
    @(negedge ck_o);
    cmd_o <= {4'h7, ba, a};
  endtask

  // ODT changes away from the CK rise so setup is never marginal
  task automatic set_odt(input logic v);
    @(negedge ck_o);
    odt_o <= v;
  endtask

  // Counts CK rises, used to let tMOD run out
  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck_o);
  endtask

  // Single strobe pulse, dly ns after a CK rise, on the lanes in ln
  task automatic strobe(input int dly, input logic [1:0] ln);
    @(posedge ck_o);
    #(dly);
    dqs_o <= ln;
    #30;
    dqs_o <= 2'b00;
  endtask
endmodule
`default_nettype wire

// [sim/dwm_top_test.sv]
// Self-checking bench for the write-leveling and calibration-pattern block
`default_nettype none
module dwm_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ck;
  dwm_pkg::dwm_cmd_s cmd;
  logic odt;
  logic [1:0] dqs;
  logic [15:0] dq_o;
  logic [15:0] dq_oe_o;
  logic rtt_dqs_on_o;
  logic rtt_dq_on_o;
  logic array_rd_o;
  logic array_wr_o;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0; // Hang guard
  int rd_cnt = 0; // Array read pulses seen
  int wr_cnt = 0; // Array write pulses seen
  logic mirror = 1'b0; // Pattern copied to bits 7:1

  dwm_ctl_model dwm_ctl_model_i (.ck_o(ck), .cmd_o(cmd), .odt_o(odt), .dqs_o(dqs));

  dwm_top dwm_top_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ck_i(ck), .cmd_i(cmd), .odt_i(odt),
    .dqs_i(dqs), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .rtt_dqs_on_o(rtt_dqs_on_o),
    .rtt_dq_on_o(rtt_dq_on_o), .array_rd_o(array_rd_o), .array_wr_o(array_wr_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o)
  );

  // 125 MHz core clock
  always #4 core_clk_i = ~core_clk_i;

  // Counts one-cycle array pulses; the run is far shorter than the ceiling
  always @(posedge core_clk_i) begin
    cycles++;
    if (array_rd_o === 1'b1) rd_cnt++;
    if (array_wr_o === 1'b1) wr_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Avalon read: request held until waitrequest is sampled low
  task automatic avs_rd(input logic [4:0] adr, output logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= adr;
    avs_read_i <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
  endtask

  // Avalon write: takes effect at the edge where waitrequest is low
  task automatic avs_wr(input logic [4:0] adr, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i <= adr;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask

  task automatic reg_is(input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    avs_rd(adr, d);
    check(d, exp, "register");
  endtask

  // One strobe, then compare the masked feedback once it has settled
  task automatic level(input int dly, input logic [15:0] m, input logic [15:0] e,
    input logic [1:0] ln = 2'b11);
    dwm_ctl_model_i.strobe(dly, ln);
    repeat (10) @(posedge core_clk_i);
    check({16'h0, dq_o & m}, {16'h0, e}, "feedback");
  endtask

  // Pattern read: latency of four CK rises, then one beat per CK edge
  task automatic burst(input logic [13:0] a, input int beats, input logic [7:0] pat);
    int n;
    logic b;
    n = 0;
    dwm_ctl_model_i.issue(dwm_pkg::CMD_RD, 3'h5, a);
    while (dq_oe_o[0] !== 1'b1) begin
      @(posedge core_clk_i);
      n++;
    end
    check({31'h0, n >= 36 && n <= 42}, 32'h1, "read latency");
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < beats; i++) begin
      b = pat[(beats == 4 && a[2]) ? i + 4 : i];
      check({16'h0, dq_o}, {16'h0, {2{mirror ? {8{b}} : {7'h00, b}}}}, "beat");
      repeat (5) @(posedge core_clk_i);
    end
    check({31'h0, dq_oe_o[0]}, 32'h0, "burst end");
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // Reset values, unmapped offset reads zero, read-only places ignore writes
    for (int i = 0; i < 6; i++) reg_is(5'(4 * i), 32'h0);
    avs_wr(dwm_pkg::OFS_STATUS, 32'hFFFFFFFF);
    avs_wr(5'h14, 32'hFFFFFFFF);
    avs_wr(dwm_pkg::OFS_CTRL, 32'h3);
    reg_is(dwm_pkg::OFS_STATUS, 32'h0);
    reg_is(5'h14, 32'h0);
    reg_is(dwm_pkg::OFS_CTRL, 32'h3);
    avs_wr(dwm_pkg::OFS_CTRL, 32'h0);
    $display("test registers done");
    // Leveling entry with Rtt_Nom RZQ/4; ODT raised too early must be ignored
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR1, 14'h0084);
    dwm_ctl_model_i.set_odt(1'b1);
    repeat (10) @(posedge core_clk_i);
    reg_is(dwm_pkg::OFS_STATUS, 32'h1);
    check({31'h0, rtt_dqs_on_o}, 32'h0, "early odt");
    dwm_ctl_model_i.wait_ck(13);
    repeat (10) @(posedge core_clk_i);
    check({30'h0, rtt_dqs_on_o, rtt_dq_on_o}, 32'h2, "odt on");
    reg_is(dwm_pkg::OFS_MR1, 32'h0084);
    // Delay sweep until the feedback goes from 0 to 1
    level(50, 16'h00FF, 16'h0000);
    level(65, 16'h00FF, 16'h0000);
    level(90, 16'h00FF, 16'h0001);
    repeat (30) @(posedge core_clk_i);
    check({16'h0, dq_o & 16'h00FF}, 32'h1, "held");
    avs_wr(dwm_pkg::OFS_CTRL, 32'h1);
    level(50, 16'hFFFF, 16'h0000);
    level(100, 16'hFFFF, 16'hFFFF);
    // Lower lane alone: it samples low while the upper lane holds its 1
    level(50, 16'hFFFF, 16'hFF00, 2'b01);
    // Output buffer off during leveling
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR1, 14'h1084);
    repeat (10) @(posedge core_clk_i);
    check({16'h0, dq_oe_o}, 32'h0, "qoff");
    // Exit: ODT low, then MRS clearing A7 and updating other bits
    dwm_ctl_model_i.set_odt(1'b0);
    repeat (10) @(posedge core_clk_i);
    check({30'h0, rtt_dqs_on_o, rtt_dq_on_o}, 32'h0, "odt off");
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR1, 14'h0246);
    dwm_ctl_model_i.wait_ck(13);
    reg_is(dwm_pkg::OFS_MR1, 32'h0246);
    reg_is(dwm_pkg::OFS_STATUS, 32'h10);
    $display("test leveling done");
    // Array accesses with pattern mode off, then on-the-fly chop enabled in MR0
    avs_wr(dwm_pkg::OFS_CTRL, 32'h0);
    dwm_ctl_model_i.issue(dwm_pkg::CMD_WR, 3'h0, 14'h0000);
    dwm_ctl_model_i.issue(dwm_pkg::CMD_RD, 3'h0, 14'h0000);
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR0, 14'h0001);
    check({rd_cnt[15:0], wr_cnt[15:0]}, 32'h00010001, "array");
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR3, 14'h0004);
    dwm_ctl_model_i.wait_ck(13);
    reg_is(dwm_pkg::OFS_STATUS, 32'h12);
    burst(14'h1000, 8, 8'hAA);
    burst(14'h1400, 8, 8'hAA);
    avs_wr(dwm_pkg::OFS_CTRL, 32'h2);
    mirror = 1'b1;
    burst(14'h0000, 4, 8'hAA);
    burst(14'h0004, 4, 8'hAA);
    dwm_ctl_model_i.issue(dwm_pkg::CMD_WR, 3'h0, 14'h0000);
    repeat (10) @(posedge core_clk_i);
    check({rd_cnt[15:0], wr_cnt[15:0]}, 32'h00010001, "redirect");
    // Pattern off with location bits set, then a reserved location
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR3, 14'h0003);
    dwm_ctl_model_i.wait_ck(13);
    dwm_ctl_model_i.issue(dwm_pkg::CMD_RD, 3'h0, 14'h0000);
    repeat (10) @(posedge core_clk_i);
    check({16'h0, rd_cnt[15:0]}, 32'h2, "array read");
    dwm_ctl_model_i.issue(dwm_pkg::CMD_MRS, dwm_pkg::BA_MR3, 14'h0005);
    dwm_ctl_model_i.wait_ck(13);
    burst(14'h1000, 8, 8'h00);
    $display("test pattern done");
    conclude();
  end
endmodule
`default_nettype wire
